//--- hdl/ext_ctrl_pkg.sv
package ext_ctrl_pkg;

    // Clock and time base
    localparam int CLK_HZ = 25_000_000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;

    // High-voltage re-enable lockout, a least time, so one extra cycle
    localparam int HV_LOCKOUT_MS = 2000;
    localparam int HV_LOCKOUT_CYCLES = HV_LOCKOUT_MS * CYCLES_PER_MS + 1;

    // Cycle-complete closure after each lamp flash
    localparam int CYCLE_END_MS = 50;
    localparam int CYCLE_END_CYCLES = CYCLE_END_MS * CYCLES_PER_MS;

    // Shortest halt closure that must be recognised, rounded down
    localparam int HALT_MIN_MS = 1;
    localparam int HALT_MIN_CYCLES = HALT_MIN_MS * CYCLES_PER_MS;

    // Counter width able to hold the longest default count
    localparam int TIMER_W = 26;

    // Contact bundle layout fed through the synchroniser
    localparam int NUM_CONTACTS = 14;
    localparam int C_HV_REQ = 0;
    localparam int C_FAULT_CLR = 1;
    localparam int C_FIRE = 2;
    localparam int C_HALT = 3;
    localparam int C_AIM = 4;
    localparam int C_EXT_EN = 5;
    localparam int C_BEAM_LSB = 6;
    localparam int C_SCHED_LSB = 9;

    // Field widths
    localparam int BEAM_W = 3;
    localparam int SCHED_W = 5;

    // Reset values
    localparam logic [BEAM_W-1:0] BEAM_RESET = 3'h0;
    localparam logic [SCHED_W-1:0] SCHED_RESET = 5'h00;

    // High-voltage state machine, one-hot
    typedef enum logic [2:0] {
        HV_OFF = 3'h1,
        HV_ON = 3'h2,
        HV_HOLD = 3'h4
    } hv_state_e;

endpackage

//--- hdl/contact_sync.sv
`timescale 1ns/1ns
module contact_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Raw contacts, closed reads as one
    input wire logic [WIDTH-1:0] contact_in,
    // Synchronised level and edge pulses
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] prev_reg;

    // First stage feeds only the second stage
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            meta_reg <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg <= contact_in;
            stable_reg <= meta_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= stable_reg;
        end
    end

    assign level_out = stable_reg;
    assign rise_out = stable_reg & ~prev_reg;
    assign fall_out = ~stable_reg & prev_reg;
endmodule

//--- hdl/external_control_input_decoder.sv
`timescale 1ns/1ns
// Functional notes
// - High voltage is on while the request contact is closed, off once open.
// - After switch-off, high voltage stays off for more than two seconds.
// - Faults raise an alarm; clear contact cancels it once the cause is gone.
// - A fire closure starts one laser pulse using the selected schedule.
// - Halt closure stops a running repeat sequence with nonzero pulse rate.
// - Halt closures of 1 ms or longer are always recognised.
// - Guide beam is on exactly while the aim contact is closed.
// - External contacts act only while the external enable is closed.
// - Each beam-select closure selects and readies its beam input unit.
// - Schedule number is the weighted sum 1, 2, 4, 8, 16 of closed inputs.
// - Cycle-complete output closes for 50 ms after each lamp flash.
// - Ready closes while high voltage is on and capacitor is charged.
// - Fault indicator stays open from a fault until it is reset.
// - Input-acceptance output follows the external enable contact.
module external_control_input_decoder
    import ext_ctrl_pkg::*;
#(
    parameter int LOCKOUT_CYCLES = ext_ctrl_pkg::HV_LOCKOUT_CYCLES,
    parameter int END_CYCLES = ext_ctrl_pkg::CYCLE_END_CYCLES,
    parameter int HALT_CYCLES = ext_ctrl_pkg::HALT_MIN_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,

    // Contact inputs from the controller, closed reads as one
    input wire logic HIGH_VOLTAGE_REQUEST,
    input wire logic FAULT_CLEAR,
    input wire logic FIRE_REQUEST,
    input wire logic HALT_REQUEST,
    input wire logic AIM_REQUEST,
    input wire logic EXTERNAL_CONTROL_ENABLE,
    input wire logic [ext_ctrl_pkg::BEAM_W-1:0] BEAM_SELECT,
    input wire logic [ext_ctrl_pkg::SCHED_W-1:0] SCHEDULE_SELECT,

    // Welder status from logic on the same clock
    input wire logic FAULT_DETECTED,
    input wire logic FAULT_CAUSE_PRESENT,
    input wire logic CAPACITOR_CHARGED,
    input wire logic LAMP_FLASHED,
    input wire logic REPEAT_RATE_NONZERO,
    input wire logic REPEAT_SEQUENCE_ACTIVE,

    // Commands to the welder
    output logic HIGH_VOLTAGE_ON,
    output logic HV_LOCKOUT_ACTIVE,
    output logic ALARM_ACTIVE,
    output logic FIRE_START,
    output logic [ext_ctrl_pkg::SCHED_W-1:0] FIRE_SCHEDULE,
    output logic REPEAT_HALT,
    output logic GUIDE_BEAM_ON,
    output logic [ext_ctrl_pkg::BEAM_W-1:0] BEAM_UNIT_SELECT,
    output logic [ext_ctrl_pkg::SCHED_W-1:0] SCHEDULE_NUMBER,

    // Status contacts back to the controller, one means closed
    output logic READY_CLOSED,
    output logic FAULT_INDICATOR_CLOSED,
    output logic CYCLE_COMPLETE_CLOSED,
    output logic INPUT_ACCEPT_CLOSED
);
    import ext_ctrl_pkg::*;

    localparam logic [TIMER_W-1:0] LOCKOUT_LOAD = TIMER_W'(LOCKOUT_CYCLES);
    localparam logic [TIMER_W-1:0] END_LOAD = TIMER_W'(END_CYCLES);
    localparam logic [TIMER_W-1:0] HALT_LOAD = TIMER_W'(HALT_CYCLES);
    localparam logic [TIMER_W-1:0] TIMER_ONE = 26'h0000001;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 26'h0000000;

    // Weighted sum of closed schedule contacts, bit n weighs 2**n
    function automatic logic [SCHED_W-1:0] sched_value(
        input logic [SCHED_W-1:0] closed
    );
        logic [SCHED_W-1:0] sum;
        sum = '0;
        for (int i = 0; i < SCHED_W; i++) begin
            if (closed[i]) begin
                sum = sum | SCHED_W'(1 << i);
            end
        end
        return sum;
    endfunction

    // Down-counter step that stops at zero
    function automatic logic [TIMER_W-1:0] count_down(
        input logic [TIMER_W-1:0] value
    );
        return (value == TIMER_ZERO) ? TIMER_ZERO : value - TIMER_ONE;
    endfunction

    logic [NUM_CONTACTS-1:0] raw_contacts;
    logic [NUM_CONTACTS-1:0] sync_level;
    logic [NUM_CONTACTS-1:0] sync_rise;
    logic enabled;
    logic hv_req;
    logic fault_clr;
    logic fire_edge;
    logic halt_closed;
    logic aim_closed;
    logic [BEAM_W-1:0] beam_closed;
    logic [SCHED_W-1:0] sched_closed;

    hv_state_e hv_state_reg;
    hv_state_e hv_state_next;
    logic [TIMER_W-1:0] lockout_cnt_reg;
    logic [TIMER_W-1:0] end_cnt_reg;
    logic [TIMER_W-1:0] halt_cnt_reg;
    logic halt_seen;
    logic alarm_reg;
    logic fire_reg;
    logic [SCHED_W-1:0] fire_sched_reg;
    logic halt_pulse_reg;
    logic guide_reg;
    logic [BEAM_W-1:0] beam_reg;
    logic [SCHED_W-1:0] sched_reg;
    logic ready_reg;
    logic accept_reg;

    // Bundle order must match the contact positions kept in the package
    assign raw_contacts = {SCHEDULE_SELECT, BEAM_SELECT,
                           EXTERNAL_CONTROL_ENABLE, AIM_REQUEST,
                           HALT_REQUEST, FIRE_REQUEST, FAULT_CLEAR,
                           HIGH_VOLTAGE_REQUEST};

    // All contacts cross into the clock domain together
    contact_sync #(
        .WIDTH(NUM_CONTACTS)
    ) u_contact_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .contact_in(raw_contacts),
        .level_out(sync_level),
        .rise_out(sync_rise),
        .fall_out()
    );

    // Command contacts are gated by the enable here; beam and schedule are gated at their registers
    assign enabled = sync_level[C_EXT_EN];
    assign hv_req = enabled & sync_level[C_HV_REQ];
    assign fault_clr = enabled & sync_level[C_FAULT_CLR];
    assign fire_edge = enabled & sync_rise[C_FIRE];
    assign halt_closed = enabled & sync_level[C_HALT];
    assign aim_closed = enabled & sync_level[C_AIM];
    assign beam_closed = sync_level[C_BEAM_LSB +: BEAM_W];
    assign sched_closed = sync_level[C_SCHED_LSB +: SCHED_W];

    // High voltage follows the request, with a hold-off after each drop
    always_comb begin
        hv_state_next = hv_state_reg;
        case (hv_state_reg)
            HV_OFF: begin
                if (hv_req) begin
                    hv_state_next = HV_ON;
                end
            end
            HV_ON: begin
                if (!hv_req) begin
                    hv_state_next = HV_HOLD;
                end
            end
            HV_HOLD: begin
                // Request is ignored here even if it closes again
                if (lockout_cnt_reg == TIMER_ONE) begin
                    hv_state_next = HV_OFF;
                end
            end
            default: begin
                hv_state_next = HV_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            hv_state_reg <= HV_OFF;
        end else begin
            hv_state_reg <= hv_state_next;
        end
    end

    // Counts one more cycle than two seconds so the wait is strictly longer
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lockout_cnt_reg <= TIMER_ZERO;
        end else if (hv_state_reg == HV_ON && !hv_req) begin
            lockout_cnt_reg <= LOCKOUT_LOAD;
        end else begin
            lockout_cnt_reg <= count_down(lockout_cnt_reg);
        end
    end

    // A new fault wins over a clear arriving in the same cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            alarm_reg <= 1'b0;
        end else if (FAULT_DETECTED) begin
            alarm_reg <= 1'b1;
        end else if (fault_clr && !FAULT_CAUSE_PRESENT) begin
            alarm_reg <= 1'b0;
        end
    end

    // One pulse per closure edge; the schedule is frozen with it
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fire_reg <= 1'b0;
            fire_sched_reg <= SCHED_RESET;
        end else begin
            fire_reg <= fire_edge;
            if (fire_edge) begin
                fire_sched_reg <= sched_reg;
            end
        end
    end

    // Halt filter: a closure counts once it has stood for the minimum
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            halt_cnt_reg <= TIMER_ZERO;
        end else if (!halt_closed) begin
            halt_cnt_reg <= TIMER_ZERO;
        end else if (halt_cnt_reg != HALT_LOAD) begin
            halt_cnt_reg <= halt_cnt_reg + TIMER_ONE;
        end
    end

    // True on one cycle only, as the count saturates just after it
    assign halt_seen = halt_closed && (halt_cnt_reg == HALT_LOAD - TIMER_ONE);

    // Only repeat sequences with a nonzero rate can be halted
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            halt_pulse_reg <= 1'b0;
        end else begin
            halt_pulse_reg <= halt_seen && REPEAT_SEQUENCE_ACTIVE &&
                              REPEAT_RATE_NONZERO;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            guide_reg <= 1'b0;
        end else begin
            // The sync delay and this one register lie between contact and beam
            guide_reg <= aim_closed;
        end
    end

    // Selections keep their last value while external control is off
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            beam_reg <= BEAM_RESET;
            sched_reg <= SCHED_RESET;
        end else if (enabled) begin
            beam_reg <= beam_closed;
            sched_reg <= sched_value(sched_closed);
        end
    end

    // Retriggers on a new flash so the closure always spans the last one
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            end_cnt_reg <= TIMER_ZERO;
        end else if (LAMP_FLASHED) begin
            end_cnt_reg <= END_LOAD;
        end else begin
            end_cnt_reg <= count_down(end_cnt_reg);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ready_reg <= 1'b0;
            accept_reg <= 1'b0;
        end else begin
            // Next state is used so ready cannot lag the high-voltage output
            ready_reg <= (hv_state_next == HV_ON) && CAPACITOR_CHARGED;
            accept_reg <= enabled;
        end
    end

    // Status contacts read one when closed; the indicator opens on a fault
    assign HIGH_VOLTAGE_ON = (hv_state_reg == HV_ON);
    assign HV_LOCKOUT_ACTIVE = (hv_state_reg == HV_HOLD);
    assign ALARM_ACTIVE = alarm_reg;
    assign FIRE_START = fire_reg;
    assign FIRE_SCHEDULE = fire_sched_reg;
    assign REPEAT_HALT = halt_pulse_reg;
    assign GUIDE_BEAM_ON = guide_reg;
    assign BEAM_UNIT_SELECT = beam_reg;
    assign SCHEDULE_NUMBER = sched_reg;
    assign READY_CLOSED = ready_reg;
    assign FAULT_INDICATOR_CLOSED = ~alarm_reg;
    assign CYCLE_COMPLETE_CLOSED = (end_cnt_reg != TIMER_ZERO);
    assign INPUT_ACCEPT_CLOSED = accept_reg;
endmodule

//--- sim/ext_ctrl_checker.sv
`timescale 1ns/1ns
module ext_ctrl_checker
    import ext_ctrl_pkg::*;
#(
    parameter int LOCKOUT_CYCLES = 20,
    parameter int END_CYCLES = 10
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Contacts and welder status
    input wire logic AIM_REQUEST,
    input wire logic EXTERNAL_CONTROL_ENABLE,
    input wire logic [ext_ctrl_pkg::SCHED_W-1:0] SCHEDULE_SELECT,
    input wire logic FAULT_DETECTED,
    input wire logic FAULT_CAUSE_PRESENT,
    input wire logic LAMP_FLASHED,
    input wire logic REPEAT_RATE_NONZERO,
    input wire logic REPEAT_SEQUENCE_ACTIVE,
    // Decoder outputs
    input wire logic HIGH_VOLTAGE_ON,
    input wire logic HV_LOCKOUT_ACTIVE,
    input wire logic ALARM_ACTIVE,
    input wire logic FIRE_START,
    input wire logic [ext_ctrl_pkg::SCHED_W-1:0] FIRE_SCHEDULE,
    input wire logic REPEAT_HALT,
    input wire logic GUIDE_BEAM_ON,
    input wire logic [ext_ctrl_pkg::SCHED_W-1:0] SCHEDULE_NUMBER,
    input wire logic READY_CLOSED,
    input wire logic FAULT_INDICATOR_CLOSED,
    input wire logic CYCLE_COMPLETE_CLOSED,
    input wire logic INPUT_ACCEPT_CLOSED
);
    // Three edges after reset the synchronisers hold only fresh samples
    logic [1:0] up_reg;
    int lock_reg;
    int cc_reg;
    always_ff @(posedge CLK) begin
        if (!RST_N) up_reg <= 2'h0;
        else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
    end
    always_ff @(posedge CLK) begin
        if (!RST_N || !HV_LOCKOUT_ACTIVE) lock_reg <= 0;
        else lock_reg <= lock_reg + 1;
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) cc_reg <= 0;
        else if (LAMP_FLASHED) cc_reg <= END_CYCLES;
        else if (cc_reg != 0) cc_reg <= cc_reg - 1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_hv_drop;
        HIGH_VOLTAGE_ON ##1 !HIGH_VOLTAGE_ON;
    endsequence
    property p_guide;
        up_reg == 2'h3 |-> GUIDE_BEAM_ON ==
            ($past(AIM_REQUEST, 3) && $past(EXTERNAL_CONTROL_ENABLE, 3));
    endproperty
    property p_sched;
        up_reg == 2'h3 && $past(EXTERNAL_CONTROL_ENABLE, 3) |->
            SCHEDULE_NUMBER == $past(SCHEDULE_SELECT, 3);
    endproperty
    property p_accept;
        up_reg == 2'h3 |->
            INPUT_ACCEPT_CLOSED == $past(EXTERNAL_CONTROL_ENABLE, 3);
    endproperty
    property p_fire;
        FIRE_START |-> FIRE_SCHEDULE == SCHEDULE_NUMBER ##1 !FIRE_START;
    endproperty
    property p_fault_ind;
        FAULT_INDICATOR_CLOSED == !ALARM_ACTIVE &&
            (!$rose(FAULT_INDICATOR_CLOSED) ||
             (!$past(FAULT_CAUSE_PRESENT) && !$past(FAULT_DETECTED)));
    endproperty
    property p_alarm_set;
        FAULT_DETECTED |=> ALARM_ACTIVE;
    endproperty
    property p_end;
        CYCLE_COMPLETE_CLOSED == (cc_reg != 0);
    endproperty
    property p_drop;
        s_hv_drop |-> HV_LOCKOUT_ACTIVE;
    endproperty
    property p_lock_len;
        $fell(HV_LOCKOUT_ACTIVE) |-> lock_reg == LOCKOUT_CYCLES;
    endproperty
    property p_ready;
        READY_CLOSED |-> HIGH_VOLTAGE_ON && !HV_LOCKOUT_ACTIVE;
    endproperty
    property p_halt;
        REPEAT_HALT |-> $past(REPEAT_SEQUENCE_ACTIVE)
            && $past(REPEAT_RATE_NONZERO) ##1 !REPEAT_HALT;
    endproperty
    a_guide: assert property (p_guide) else $error("guide beam");
    a_sched: assert property (p_sched) else $error("schedule");
    a_accept: assert property (p_accept) else $error("accept");
    a_fire: assert property (p_fire) else $error("fire pulse");
    a_fault_ind: assert property (p_fault_ind) else $error("ind");
    a_alarm_set: assert property (p_alarm_set) else $error("alarm");
    a_end: assert property (p_end) else $error("cycle end");
    a_drop: assert property (p_drop) else $error("no lockout");
    a_lock_len: assert property (p_lock_len) else $error("lock");
    a_ready: assert property (p_ready) else $error("ready");
    a_halt: assert property (p_halt) else $error("halt");
endmodule
bind external_control_input_decoder ext_ctrl_checker #(
    .LOCKOUT_CYCLES(LOCKOUT_CYCLES), .END_CYCLES(END_CYCLES)
) chk_u (.CLK, .RST_N, .AIM_REQUEST, .EXTERNAL_CONTROL_ENABLE,
    .SCHEDULE_SELECT, .FAULT_DETECTED, .FAULT_CAUSE_PRESENT, .LAMP_FLASHED,
    .REPEAT_RATE_NONZERO, .REPEAT_SEQUENCE_ACTIVE, .HIGH_VOLTAGE_ON,
    .HV_LOCKOUT_ACTIVE, .ALARM_ACTIVE, .FIRE_START, .FIRE_SCHEDULE,
    .REPEAT_HALT, .GUIDE_BEAM_ON, .SCHEDULE_NUMBER, .READY_CLOSED,
    .FAULT_INDICATOR_CLOSED, .CYCLE_COMPLETE_CLOSED, .INPUT_ACCEPT_CLOSED);

//--- sim/plc_model.sv
`timescale 1ns/1ns
module plc_model
    import ext_ctrl_pkg::*;
#(
    parameter int HOLD_CYCLES = 6,
    parameter int GAP_CYCLES = 8
) (
    // Clock
    input wire logic clk,
    // Contacts, closed is one
    output logic [NUM_CONTACTS-1:0] pins
);
    initial pins = '0;
    task automatic drive(input int lsb, input int w, input logic [4:0] v);
        @(posedge clk);
        #2;
        for (int i = 0; i < w; i++) pins[lsb+i] = v[i];
    endtask
    // Hold and gap are scaled down so the run stays short
    task automatic fire(input logic [4:0] sched);
        drive(C_SCHED_LSB, SCHED_W, sched);
        drive(C_HALT, 1, 5'h01);
        drive(C_FIRE, 1, 5'h01);
        repeat (HOLD_CYCLES) @(posedge clk);
        drive(C_FIRE, 1, 5'h00);
        repeat (GAP_CYCLES) @(posedge clk);
        #2;
    endtask
    task automatic halt_pulse(input int n);
        drive(C_HALT, 1, 5'h00);
        drive(C_HALT, 1, 5'h01);
        repeat (n - 1) @(posedge clk);
        drive(C_HALT, 1, 5'h00);
    endtask
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import ext_ctrl_pkg::*;
    localparam int L = 20;
    localparam int E = 10;
    localparam int H = 4;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic FAULT_DETECTED = 1'b0, FAULT_CAUSE_PRESENT = 1'b0;
    logic CAPACITOR_CHARGED = 1'b0, LAMP_FLASHED = 1'b0;
    logic REPEAT_RATE_NONZERO = 1'b0, REPEAT_SEQUENCE_ACTIVE = 1'b0;
    logic HIGH_VOLTAGE_ON, HV_LOCKOUT_ACTIVE, ALARM_ACTIVE, FIRE_START;
    logic REPEAT_HALT, GUIDE_BEAM_ON, READY_CLOSED, FAULT_INDICATOR_CLOSED;
    logic CYCLE_COMPLETE_CLOSED, INPUT_ACCEPT_CLOSED;
    logic [SCHED_W-1:0] FIRE_SCHEDULE, SCHEDULE_NUMBER;
    logic [BEAM_W-1:0] BEAM_UNIT_SELECT;
    logic [NUM_CONTACTS-1:0] pins;
    logic [SCHED_W-1:0] exp_q[$];
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] n_halt = 8'h00;
    initial forever #20 CLK = ~CLK;
    plc_model plc_u (.clk(CLK), .pins(pins));
    external_control_input_decoder #(
        .LOCKOUT_CYCLES(L), .END_CYCLES(E), .HALT_CYCLES(H)
    ) dut_u (.CLK, .RST_N, .HIGH_VOLTAGE_REQUEST(pins[C_HV_REQ]),
        .FAULT_CLEAR(pins[C_FAULT_CLR]), .FIRE_REQUEST(pins[C_FIRE]),
        .HALT_REQUEST(pins[C_HALT]), .AIM_REQUEST(pins[C_AIM]),
        .EXTERNAL_CONTROL_ENABLE(pins[C_EXT_EN]),
        .BEAM_SELECT(pins[C_BEAM_LSB+:BEAM_W]),
        .SCHEDULE_SELECT(pins[C_SCHED_LSB+:SCHED_W]), .FAULT_DETECTED,
        .FAULT_CAUSE_PRESENT, .CAPACITOR_CHARGED, .LAMP_FLASHED,
        .REPEAT_RATE_NONZERO, .REPEAT_SEQUENCE_ACTIVE, .HIGH_VOLTAGE_ON,
        .HV_LOCKOUT_ACTIVE, .ALARM_ACTIVE, .FIRE_START, .FIRE_SCHEDULE,
        .REPEAT_HALT, .GUIDE_BEAM_ON, .BEAM_UNIT_SELECT, .SCHEDULE_NUMBER,
        .READY_CLOSED, .FAULT_INDICATOR_CLOSED, .CYCLE_COMPLETE_CLOSED,
        .INPUT_ACCEPT_CLOSED);
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        check_count++;
        if (got !== want) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask
    task automatic close_out;
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Every fire pulse must match the oldest schedule noted by the driver
    always @(negedge CLK) begin
        if (REPEAT_HALT === 1'b1) n_halt++;
        if (FIRE_START === 1'b1) begin
            if (exp_q.size() == 0) chk(8'hFF, 8'h00);
            else chk(8'(FIRE_SCHEDULE), 8'(exp_q.pop_front()));
        end
    end
    initial begin
        #(40 * 5000);
        $display("BAD %0t timeout", $time);
        n_errors++;
        close_out();
    end
    initial begin
        logic [4:0] s;
        logic [7:0] n;
        s = 5'($urandom(29));
        tick(5);
        RST_N = 1'b1;
        plc_u.drive(C_EXT_EN, 1, 5'h01);
        tick(4);
        chk(8'(INPUT_ACCEPT_CLOSED), 8'h01);
        for (int i = 0; i < 8; i++) begin
            s = (i < 5) ? (5'h01 << i) : 5'($urandom);
            exp_q.push_back(s);
            plc_u.fire(s);
            chk(8'(SCHEDULE_NUMBER), 8'(s));
        end
        for (int i = 0; i < 3; i++) begin
            plc_u.drive(C_BEAM_LSB, BEAM_W, 5'h01 << i);
            tick(4);
            chk(8'(BEAM_UNIT_SELECT), 8'h01 << i);
        end
        plc_u.drive(C_AIM, 1, 5'h01);
        tick(4);
        chk(8'(GUIDE_BEAM_ON), 8'h01);
        plc_u.drive(C_AIM, 1, 5'h00);
        tick(4);
        chk(8'(GUIDE_BEAM_ON), 8'h00);
        CAPACITOR_CHARGED = 1'b1;
        plc_u.drive(C_HV_REQ, 1, 5'h01);
        tick(4);
        chk(8'(HIGH_VOLTAGE_ON), 8'h01);
        chk(8'(READY_CLOSED), 8'h01);
        plc_u.drive(C_HV_REQ, 1, 5'h00);
        plc_u.drive(C_HV_REQ, 1, 5'h01);
        tick(8);
        chk(8'(HIGH_VOLTAGE_ON), 8'h00);
        chk(8'(HV_LOCKOUT_ACTIVE), 8'h01);
        tick(L + 4);
        chk(8'(HIGH_VOLTAGE_ON), 8'h01);
        FAULT_CAUSE_PRESENT = 1'b1;
        FAULT_DETECTED = 1'b1;
        tick(1);
        FAULT_DETECTED = 1'b0;
        plc_u.drive(C_FAULT_CLR, 1, 5'h01);
        tick(4);
        chk(8'(ALARM_ACTIVE), 8'h01);
        chk(8'(FAULT_INDICATOR_CLOSED), 8'h00);
        FAULT_CAUSE_PRESENT = 1'b0;
        tick(2);
        chk(8'(ALARM_ACTIVE), 8'h00);
        chk(8'(FAULT_INDICATOR_CLOSED), 8'h01);
        LAMP_FLASHED = 1'b1;
        tick(1);
        LAMP_FLASHED = 1'b0;
        n = 8'h00;
        repeat (E + 5) begin
            @(negedge CLK);
            n = n + 8'(CYCLE_COMPLETE_CLOSED);
        end
        chk(n, 8'(E));
        tick(1);
        REPEAT_RATE_NONZERO = 1'b1;
        REPEAT_SEQUENCE_ACTIVE = 1'b1;
        plc_u.halt_pulse(H);
        tick(5);
        chk(n_halt, 8'h01);
        plc_u.halt_pulse(H - 1);
        tick(5);
        chk(n_halt, 8'h01);
        REPEAT_RATE_NONZERO = 1'b0;
        plc_u.halt_pulse(H);
        tick(5);
        chk(n_halt, 8'h01);
        plc_u.drive(C_EXT_EN, 1, 5'h00);
        plc_u.drive(C_AIM, 1, 5'h01);
        plc_u.fire(5'h03);
        chk(8'(INPUT_ACCEPT_CLOSED), 8'h00);
        chk(8'(GUIDE_BEAM_ON), 8'h00);
        chk(8'(HIGH_VOLTAGE_ON), 8'h00);
        chk(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule
